/* File: core/pim_regs.vh */
// register indices, field positions, reset values and write masks for the mask block
`ifndef PIM_REGS_VH
`define PIM_REGS_VH

// register indices; the byte address on the bus is four times the index
`define PIM_IDX_TOP_MASK      8'h07
`define PIM_IDX_BT_MASK       8'h08
`define PIM_IDX_ONOFF_MASK    8'h09
`define PIM_IDX_BUCK_MASK     8'h0a
`define PIM_IDX_BT_STAT       8'h10
`define PIM_IDX_ONOFF_STAT    8'h11
`define PIM_IDX_BUCK_STAT     8'h12

// reset values
`define PIM_RST_TOP_MASK      8'h02
`define PIM_RST_BT_MASK       8'h02
`define PIM_RST_ONOFF_MASK    8'h3f
`define PIM_RST_BUCK_MASK     8'hff

// bits that hold storage; every other bit is reserved
`define PIM_WMASK_TOP         8'hfb
`define PIM_WMASK_BT          8'h07
`define PIM_WMASK_ONOFF       8'h3f
`define PIM_WMASK_BUCK        8'hff

// top mask register fields
`define PIM_TOP_ALL_SRC_BIT   0
`define PIM_TOP_ONOFF_BIT     1
`define PIM_TOP_SD_BIT        6
`define PIM_TOP_GRES_BIT      7

// battery and temperature mask fields
`define PIM_BT_BATT_RST_BIT   2
`define PIM_BT_TEMP_A_BIT     1
`define PIM_BT_TEMP_B_BIT     0

// on/off mask fields
`define PIM_OO_AC_HIGH_BIT    5
`define PIM_OO_AC_LOW_BIT     4
`define PIM_OO_EN_RISE_BIT    3
`define PIM_OO_EN_FALL_BIT    2
`define PIM_OO_EN_HOLD_BIT    1
`define PIM_OO_MR_WARN_BIT    0

// group widths
`define PIM_BT_W              3
`define PIM_OO_W              6
`define PIM_BUCK_W            8

`endif

/* File: core/pim_sticky.v */
// sticky event flags, cleared by writing one, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module pim_sticky #(
	parameter W = 8
) (
	input  wire         i_clk,
	input  wire         i_rst_n,
	input  wire [W-1:0] i_set,
	input  wire [W-1:0] i_clr,
	output wire [W-1:0] o_flag
);
	reg  [W-1:0] flag_r;
	wire [W-1:0] flag_nxt;

	// a set in the clearing cycle survives so no event is lost
	assign flag_nxt = (flag_r & ~i_clr) | i_set;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_r <= {W{1'b0}};
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign o_flag = flag_r;
endmodule // pim_sticky
`default_nettype wire

/* File: core/pim_sync.v */
// two-flop synchroniser with rising-edge pulse per bit
`timescale 1ns/10ps
`default_nettype none
module pim_sync #(
	parameter W = 8
) (
	input  wire         i_clk,
	input  wire         i_rst_n,
	input  wire [W-1:0] i_async,
	output wire [W-1:0] o_rise
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	reg [W-1:0] prev_r;

	// first stage feeds only the second; edge taken from later stages
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
			prev_r <= {W{1'b0}};
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// one-cycle pulse on each low-to-high change
	assign o_rise = sync_r & ~prev_r;
endmodule // pim_sync
`default_nettype wire

/* File: core/pim_top.v */
// interrupt mask registers, event flags and interrupt pin gating with apb access
//
// Summary of operation
// - the all-source mask bit 0 of the top mask blocks every source from the interrupt pin.
// - the global-resource mask blocks only the battery and temperature group from the pin.
// - reserved mask bits do nothing, ignore writes and read back as zero.
// - index 0x08 holds battery-reset (bit 2), temp alarm a (bit 1), temp alarm b (bit 0).
// - after reset index 0x08 reads temp alarm a set, all other bits clear.
// - index 0x09 holds six on/off masks, bits 5 down to 0, each resetting to one.
// - the manual-reset warning mask at bit 0 of index 0x09 gates that warning.
// - index 0x0a holds eight buck fault masks, buck a at bit 7 to buck d at bit 0, reset one.
// - a masked buck fault still sets its flag but raises no power-good irq and no power-down.
`timescale 1ns/10ps
`default_nettype none
`include "pim_regs.vh"
module pim_top (
	input  wire                   I_MCLK,
	input  wire                   I_RESETN,
	input  wire                   I_PSEL,
	input  wire                   I_PENABLE,
	input  wire                   I_PWRITE,
	input  wire [9:0]             I_PADDR,
	input  wire [31:0]            I_PWDATA,
	output wire [31:0]            O_PRDATA,
	output wire                   O_PREADY,
	output wire                   O_PSLVERR,
	input  wire [`PIM_BT_W-1:0]   I_BT_EVT,
	input  wire [`PIM_OO_W-1:0]   I_ONOFF_EVT,
	input  wire [`PIM_BUCK_W-1:0] I_BUCK_FAULT,
	output wire                   O_IRQ_OUT_N,
	output wire                   O_POWER_GOOD_IRQ,
	output wire                   O_POWERDOWN_REQ
);
	// register select codes
	localparam [2:0] SEL_NONE   = 3'h0;
	localparam [2:0] SEL_TOP    = 3'h1;
	localparam [2:0] SEL_BT     = 3'h2;
	localparam [2:0] SEL_OO     = 3'h3;
	localparam [2:0] SEL_BUCK   = 3'h4;
	localparam [2:0] SEL_BT_ST  = 3'h5;
	localparam [2:0] SEL_OO_ST  = 3'h6;
	localparam [2:0] SEL_BUCK_ST = 3'h7;

	reg  [7:0]             top_mask_r;
	reg  [7:0]             top_mask_nxt;
	reg  [7:0]             battery_temp_irq_mask_r;
	reg  [7:0]             battery_temp_irq_mask_nxt;
	reg  [7:0]             on_off_irq_mask_r;
	reg  [7:0]             on_off_irq_mask_nxt;
	reg  [7:0]             buck_fault_irq_mask_r;
	reg  [7:0]             buck_fault_irq_mask_nxt;
	reg  [31:0]            prdata_r;
	reg  [31:0]            prdata_nxt;
	reg                    irq_r;
	reg                    irq_nxt;
	reg                    pgood_r;
	reg                    pgood_nxt;
	reg                    pdown_r;
	reg                    pdown_nxt;
	wire [`PIM_BT_W-1:0]   bt_rise;
	wire [`PIM_OO_W-1:0]   oo_rise;
	wire [`PIM_BUCK_W-1:0] buck_rise;
	wire [`PIM_BT_W-1:0]   bt_flag;
	wire [`PIM_OO_W-1:0]   oo_flag;
	wire [`PIM_BUCK_W-1:0] buck_flag;
	wire [2:0]             sel;
	wire                   setup_ph;
	wire                   wr_acc;
	wire [7:0]             wbyte;
	wire                   all_src_mask;
	wire                   global_resource_mask;
	wire                   top_sd_mask;
	wire                   top_onoff_mask;
	wire                   main_batt_reset_mask;
	wire                   temp_alarm_a_mask;
	wire                   temp_alarm_b_mask;
	wire                   manual_reset_warn_mask;
	wire [`PIM_BT_W-1:0]   bt_live;
	wire [`PIM_OO_W-1:0]   oo_live;
	wire [`PIM_BUCK_W-1:0] buck_live;
	wire                   bt_grp;
	wire                   oo_grp;
	wire                   buck_grp;

	// map a byte address onto a register select; unaligned or unknown gives none
	function [2:0] reg_sel;
		input [9:0] addr;
		begin
			if (addr[1:0] != 2'b00) begin
				reg_sel = SEL_NONE;
			end else begin
				case (addr[9:2])
					`PIM_IDX_TOP_MASK:   reg_sel = SEL_TOP;
					`PIM_IDX_BT_MASK:    reg_sel = SEL_BT;
					`PIM_IDX_ONOFF_MASK: reg_sel = SEL_OO;
					`PIM_IDX_BUCK_MASK:  reg_sel = SEL_BUCK;
					`PIM_IDX_BT_STAT:    reg_sel = SEL_BT_ST;
					`PIM_IDX_ONOFF_STAT: reg_sel = SEL_OO_ST;
					`PIM_IDX_BUCK_STAT:  reg_sel = SEL_BUCK_ST;
					default:             reg_sel = SEL_NONE;
				endcase
			end
		end
	endfunction

	// merge a write into a mask register, keeping reserved bits at zero
	function [7:0] mask_wr;
		input [7:0] data;
		input [7:0] wmask;
		begin
			mask_wr = data & wmask;
		end
	endfunction

	// event inputs arrive from analog monitors, so synchronise first
	// limitation: an event level shorter than one clock may be missed
	pim_sync #(.W(`PIM_BT_W)) u_sync_bt (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RESETN),
		.i_async (I_BT_EVT),
		.o_rise  (bt_rise)
	);

	pim_sync #(.W(`PIM_OO_W)) u_sync_oo (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RESETN),
		.i_async (I_ONOFF_EVT),
		.o_rise  (oo_rise)
	);

	pim_sync #(.W(`PIM_BUCK_W)) u_sync_buck (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RESETN),
		.i_async (I_BUCK_FAULT),
		.o_rise  (buck_rise)
	);

	// apb phases and the register under access
	assign sel      = reg_sel(I_PADDR);
	assign setup_ph = I_PSEL & ~I_PENABLE;
	assign wr_acc   = I_PSEL & I_PENABLE & I_PWRITE;
	assign wbyte    = I_PWDATA[7:0];

	// status flags, write one to clear
	pim_sticky #(.W(`PIM_BT_W)) u_flag_bt (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RESETN),
		.i_set   (bt_rise),
		.i_clr   ((wr_acc && sel == SEL_BT_ST) ? wbyte[`PIM_BT_W-1:0] : {`PIM_BT_W{1'b0}}),
		.o_flag  (bt_flag)
	);

	pim_sticky #(.W(`PIM_OO_W)) u_flag_oo (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RESETN),
		.i_set   (oo_rise),
		.i_clr   ((wr_acc && sel == SEL_OO_ST) ? wbyte[`PIM_OO_W-1:0] : {`PIM_OO_W{1'b0}}),
		.o_flag  (oo_flag)
	);

	pim_sticky #(.W(`PIM_BUCK_W)) u_flag_buck (
		.i_clk   (I_MCLK),
		.i_rst_n (I_RESETN),
		.i_set   (buck_rise),
		.i_clr   ((wr_acc && sel == SEL_BUCK_ST) ? wbyte : {`PIM_BUCK_W{1'b0}}),
		.o_flag  (buck_flag)
	);

	// next mask values; only an access-phase write to a mapped mask moves one
	always @* begin
		top_mask_nxt              = top_mask_r;
		battery_temp_irq_mask_nxt = battery_temp_irq_mask_r;
		on_off_irq_mask_nxt       = on_off_irq_mask_r;
		buck_fault_irq_mask_nxt   = buck_fault_irq_mask_r;
		if (wr_acc) begin
			case (sel)
				SEL_TOP:  top_mask_nxt              = mask_wr(wbyte, `PIM_WMASK_TOP);
				SEL_BT:   battery_temp_irq_mask_nxt = mask_wr(wbyte, `PIM_WMASK_BT);
				SEL_OO:   on_off_irq_mask_nxt       = mask_wr(wbyte, `PIM_WMASK_ONOFF);
				SEL_BUCK: buck_fault_irq_mask_nxt   = mask_wr(wbyte, `PIM_WMASK_BUCK);
				// status and unmapped places leave the masks alone
				default:  top_mask_nxt              = top_mask_r;
			endcase
		end
	end

	// mask registers; kept writable, else the gating could never be opened
	always @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			top_mask_r              <= `PIM_RST_TOP_MASK;
			// temp alarm a masked, rest clear
			battery_temp_irq_mask_r <= `PIM_RST_BT_MASK;
			on_off_irq_mask_r       <= `PIM_RST_ONOFF_MASK;
			buck_fault_irq_mask_r   <= `PIM_RST_BUCK_MASK;
		end else begin
			top_mask_r              <= top_mask_nxt;
			battery_temp_irq_mask_r <= battery_temp_irq_mask_nxt;
			on_off_irq_mask_r       <= on_off_irq_mask_nxt;
			buck_fault_irq_mask_r   <= buck_fault_irq_mask_nxt;
		end
	end

	// read data captured in the setup cycle so it is stable in the access cycle
	always @* begin
		prdata_nxt = 32'h0000_0000;
		case (sel)
			SEL_TOP:     prdata_nxt[7:0] = top_mask_r;
			SEL_BT:      prdata_nxt[7:0] = battery_temp_irq_mask_r;
			SEL_OO:      prdata_nxt[7:0] = on_off_irq_mask_r;
			SEL_BUCK:    prdata_nxt[7:0] = buck_fault_irq_mask_r;
			SEL_BT_ST:   prdata_nxt[`PIM_BT_W-1:0] = bt_flag;
			SEL_OO_ST:   prdata_nxt[`PIM_OO_W-1:0] = oo_flag;
			SEL_BUCK_ST: prdata_nxt[`PIM_BUCK_W-1:0] = buck_flag;
			default:     prdata_nxt = 32'h0000_0000;
		endcase
	end

	// a flag set between setup and access shows on the next read only
	always @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup_ph) begin
			prdata_r <= prdata_nxt;
		end
	end

	// zero wait states; unmapped addresses answer with an error
	// limitation: no back-pressure, every access phase lasts one cycle
	assign O_PREADY  = 1'b1;
	assign O_PSLVERR = I_PSEL & I_PENABLE & (sel == SEL_NONE);
	assign O_PRDATA  = prdata_r;

	// named mask fields
	assign all_src_mask           = top_mask_r[`PIM_TOP_ALL_SRC_BIT];
	assign global_resource_mask   = top_mask_r[`PIM_TOP_GRES_BIT];
	assign top_sd_mask            = top_mask_r[`PIM_TOP_SD_BIT];
	assign top_onoff_mask         = top_mask_r[`PIM_TOP_ONOFF_BIT];
	assign main_batt_reset_mask   = battery_temp_irq_mask_r[`PIM_BT_BATT_RST_BIT];
	assign temp_alarm_a_mask      = battery_temp_irq_mask_r[`PIM_BT_TEMP_A_BIT];
	assign temp_alarm_b_mask      = battery_temp_irq_mask_r[`PIM_BT_TEMP_B_BIT];
	assign manual_reset_warn_mask = on_off_irq_mask_r[`PIM_OO_MR_WARN_BIT];

	// a one in a mask hides its source
	assign bt_live[`PIM_BT_BATT_RST_BIT] = bt_flag[`PIM_BT_BATT_RST_BIT] & ~main_batt_reset_mask;
	assign bt_live[`PIM_BT_TEMP_A_BIT]   = bt_flag[`PIM_BT_TEMP_A_BIT] & ~temp_alarm_a_mask;
	assign bt_live[`PIM_BT_TEMP_B_BIT]   = bt_flag[`PIM_BT_TEMP_B_BIT] & ~temp_alarm_b_mask;

	// warning gated by its own mask
	assign oo_live[`PIM_OO_MR_WARN_BIT] = oo_flag[`PIM_OO_MR_WARN_BIT] & ~manual_reset_warn_mask;
	assign oo_live[`PIM_OO_W-1:1]       = oo_flag[`PIM_OO_W-1:1]
	                                      & ~on_off_irq_mask_r[`PIM_OO_W-1:1];

	assign buck_live = buck_flag & ~buck_fault_irq_mask_r;
	// top sd mask gates only the pin; power-good and power-down see the buck masks

	// global-resource mask hits only this group
	assign bt_grp   = (|bt_live) & ~global_resource_mask;
	assign oo_grp   = (|oo_live) & ~top_onoff_mask;
	assign buck_grp = (|buck_live) & ~top_sd_mask;

	always @* begin
		irq_nxt = (bt_grp | oo_grp | buck_grp) & ~all_src_mask;
	end

	// power-good irq follows any unmasked fault flag
	always @* begin
		pgood_nxt = |buck_live;
	end

	// power-down only for a new unmasked fault edge
	// unmasking an old flag later does not request, so a stale fault cannot power down
	always @* begin
		pdown_nxt = |(buck_rise & ~buck_fault_irq_mask_r);
	end

	// pin and fault outputs registered to keep glitches off the pins
	always @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			irq_r   <= 1'b0;
			pgood_r <= 1'b0;
			pdown_r <= 1'b0;
		end else begin
			irq_r   <= irq_nxt;
			// power-good and power-down held off by the buck masks
			pgood_r <= pgood_nxt;
			pdown_r <= pdown_nxt;
		end
	end

	// active-low pin, so reset leaves it high and idle
	assign O_IRQ_OUT_N      = ~irq_r;
	assign O_POWER_GOOD_IRQ = pgood_r;
	assign O_POWERDOWN_REQ  = pdown_r;
endmodule // pim_top
`default_nettype wire

/* File: tb/pim_cpu.sv */
// processor model that counts requests on the interrupt pin
`timescale 1ns/10ps
`default_nettype none
module pim_cpu (
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_irq_n,
	output var  logic [7:0] o_hits
);
	logic irq_n_r;
	// the pin is a level, so only the falling front counts as a new request
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_n_r <= 1'b1;
			o_hits  <= 8'h00;
		end else begin
			irq_n_r <= i_irq_n;
			if (irq_n_r && !i_irq_n) begin
				o_hits <= o_hits + 8'h01;
			end
		end
	end
endmodule // pim_cpu
`default_nettype wire

/* File: tb/pim_props.sv */
// checker for the mask block ports
`timescale 1ns/10ps
`default_nettype none
module pim_props (
	input wire logic        I_MCLK,
	input wire logic        I_RESETN,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [9:0]  I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PSLVERR,
	input wire logic        O_IRQ_OUT_N,
	input wire logic        O_POWER_GOOD_IRQ,
	input wire logic        O_POWERDOWN_REQ
);
	logic       all_m_r;
	logic [7:0] bk_m_r;
	// bus decode seen from the pins
	wire acc = I_PSEL && I_PENABLE;
	wire wr  = acc && I_PWRITE;
	wire map = I_PADDR inside {10'h1c, 10'h20, 10'h24, 10'h28, 10'h40, 10'h44, 10'h48};
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_RESETN);
	// shadow masks; writes land at the access edge, as in the block
	always_ff @(posedge I_MCLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			all_m_r <= 1'b0;
			bk_m_r  <= 8'hff;
		end else if (wr && I_PADDR == 10'h1c) begin
			all_m_r <= I_PWDATA[0];
		end else if (wr && I_PADDR == 10'h28) begin
			bk_m_r <= I_PWDATA[7:0];
		end
	end
	rd_upper_a: assert property (acc |-> O_PRDATA[31:8] == 24'h0)
		else $error("read data upper bits set");
	err_unmapped_a: assert property (acc && !map |-> O_PSLVERR)
		else $error("no error on unmapped access");
	err_mapped_a: assert property (acc && map |-> !O_PSLVERR)
		else $error("error on mapped access");
	err_idle_a: assert property (!acc |-> !O_PSLVERR)
		else $error("error outside access phase");
	reset_idle_a: assert property ($rose(I_RESETN) |-> O_IRQ_OUT_N && !O_POWER_GOOD_IRQ)
		else $error("outputs not idle after reset");
	all_mask_a: assert property (all_m_r |=> O_IRQ_OUT_N)
		else $error("pin low under all-source mask");
	buck_pgood_a: assert property (bk_m_r == 8'hff |=> !O_POWER_GOOD_IRQ)
		else $error("power-good raised while all masked");
	buck_pwrdn_a: assert property ((bk_m_r == 8'hff) [*2] |=> !O_POWERDOWN_REQ)
		else $error("power-down while all masked");
	cover property (!O_IRQ_OUT_N);
	cover property (O_POWERDOWN_REQ);
	cover property (acc && O_PSLVERR);
endmodule // pim_props
bind pim_top pim_props u_props (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
	.O_PRDATA(O_PRDATA), .O_PSLVERR(O_PSLVERR), .O_IRQ_OUT_N(O_IRQ_OUT_N),
	.O_POWER_GOOD_IRQ(O_POWER_GOOD_IRQ), .O_POWERDOWN_REQ(O_POWERDOWN_REQ));
`default_nettype wire

/* File: tb/pim_top_bench.sv */
// self-checking bench for the interrupt mask block
`timescale 1ns/10ps
`default_nettype none
module pim_top_bench;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [2:0]  bt_evt = 3'h0;
	logic [5:0]  oo_evt = 6'h0;
	logic [7:0]  bk_flt = 8'h00;
	logic [31:0] rd, r1, r2;
	logic        err;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq_n, pgood, pdown;
	wire  [7:0]  hits;
	integer      fails = 0, tests_run = 0, seed = 72784, pd_cnt = 0, pd_exp = 0, hit_exp = 0;
	always #2 mclk = ~mclk;
	// count power-down pulses away from the launching edge
	always @(negedge mclk) if (pdown === 1'b1) pd_cnt++;
	pim_top u_pim_top (.I_MCLK(mclk), .I_RESETN(resetn), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_BT_EVT(bt_evt), .I_ONOFF_EVT(oo_evt),
		.I_BUCK_FAULT(bk_flt), .O_IRQ_OUT_N(irq_n), .O_POWER_GOOD_IRQ(pgood),
		.O_POWERDOWN_REQ(pdown));
	pim_cpu u_pim_cpu (.i_clk(mclk), .i_rst_n(resetn), .i_irq_n(irq_n), .o_hits(hits));
	task automatic close_out;
		if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen high
	task automatic apb(input logic [9:0] a, input logic w, input logic [31:0] d);
		integer n;
		n = 0;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 16) begin
			fails++;
			$display("BAD %0t no ready from slave", $time);
			close_out();
		end
	endtask
	// pin level expected from masks and the events present
	function automatic logic exp_irq_n(input logic [7:0] t, b, o, k, input logic [16:0] e);
		logic h;
		h = (|(e[16:14] & ~b[2:0]) & ~t[7]) | (|(e[13:8] & ~o[5:0]) & ~t[1]);
		h = h | (|(e[7:0] & ~k) & ~t[6]);
		return ~(h & ~t[0]);
	endfunction
	// set masks, fire events, check pin, power-good and buck flags, then drop the events and clear the flags
	task automatic run_case(input logic [7:0] t, b, o, k, input logic [16:0] e);
		apb(10'h1c, 1'b1, {24'h0, t & 8'hfb});
		apb(10'h20, 1'b1, {24'h0, b & 8'h07});
		apb(10'h24, 1'b1, {24'h0, o & 8'h3f});
		apb(10'h28, 1'b1, {24'h0, k});
		{bt_evt, oo_evt, bk_flt} <= e;
		repeat (8) @(posedge mclk);
		chk(irq_n, exp_irq_n(t, b, o, k, e));
		chk(pgood, |(e[7:0] & ~k));
		apb(10'h48, 1'b0, 32'h0);
		chk(rd, e[7:0]);
		// faults rising together make one power-down request
		pd_exp += (|(e[7:0] & ~k)) ? 1 : 0;
		if (!exp_irq_n(t, b, o, k, e)) hit_exp++;
		{bt_evt, oo_evt, bk_flt} <= 17'h0;
		repeat (4) @(posedge mclk);
		apb(10'h40, 1'b1, 32'h07);
		apb(10'h44, 1'b1, 32'h3f);
		apb(10'h48, 1'b1, 32'hff);
		repeat (3) @(posedge mclk);
		chk(irq_n, 1'b1);
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		resetn <= 1'b1;
		apb(10'h1c, 1'b0, 32'h0);
		chk(rd, 32'h02);
		apb(10'h20, 1'b0, 32'h0);
		chk(rd, 32'h02);
		apb(10'h24, 1'b0, 32'h0);
		chk(rd, 32'h3f);
		apb(10'h28, 1'b0, 32'h0);
		chk(rd, 32'hff);
		// unmapped place: write dropped, read zero with error
		apb(10'h30, 1'b1, 32'hff);
		apb(10'h30, 1'b0, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		// a misaligned byte address is no register either
		apb(10'h21, 1'b0, 32'h0);
		chk({31'h0, err}, 32'h1);
		// reserved bits keep no value
		apb(10'h20, 1'b1, 32'hff);
		apb(10'h20, 1'b0, 32'h0);
		chk(rd, 32'h07);
		apb(10'h24, 1'b1, 32'hff);
		apb(10'h24, 1'b0, 32'h0);
		chk(rd, 32'h3f);
		// hand-written corners of the gating
		run_case(8'h01, 8'h00, 8'h00, 8'h00, 17'h1ffff);
		run_case(8'h80, 8'h00, 8'h00, 8'h00, 17'h10000);
		run_case(8'h80, 8'h00, 8'h00, 8'h00, 17'h00100);
		run_case(8'h00, 8'h00, 8'h01, 8'h00, 17'h00100);
		run_case(8'h00, 8'h05, 8'h3f, 8'h7f, 17'h00080);
		run_case(8'h00, 8'h07, 8'h3f, 8'hff, 17'h000ff);
		for (int i = 0; i < 14; i++) begin
			r1 = $random(seed);
			r2 = $random(seed);
			run_case(r1[7:0] & 8'hc3, r1[15:8], r1[23:16], r1[31:24], r2[16:0]);
		end
		chk(pd_cnt, pd_exp);
		chk(hits, hit_exp);
		close_out();
	end
endmodule // pim_top_bench
`default_nettype wire
